// *** hdl/external_irq_pin_latch.sv ***
// External interrupt pin latch with APB status and control register
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "ext_irq_defines.svh"

// Notes on behaviour
// (RQ1) Low pin latches request per sensitivity
// (RQ2) Vector fetch acknowledge clears the latch
// (RQ3) Writing 1 to acknowledge clears latch
// (RQ4) Reset clears the request latch
// (RQ5) Edge only after reset, level optional
// (RQ6) Trigger after acknowledge sets latch again
// (RQ7) Pending flag ignores the mask
// (RQ8) Mask withholds request from CPU
// (RQ9) CPU global mask blocks all requests
// (RQ10) Level mode holds request while pin low
// (RQ11) Level mode clears after ack and high
// (RQ12) Reset clears latch and sensitivity bit
// (RQ13) Edge mode acknowledge clears at once
// (RQ14) Active in wait, unmasked request wakes
// (RQ15) Asynchronous stop wake-up when unmasked
// (RQ16) Break clears allowed when enable set
// (RQ17) Break with enable clear freezes status; here a vector fetch still clears the latch
// (RQ18) Two-step clear frozen during break
// (RQ19) Pending flag read-only, one when pending
// (RQ20) Acknowledge bit write-only, reads zero
// (RQ21) Sensitivity bit: one adds low levels
// (RQ22) Request is pending and not masked
module external_irq_pin_latch (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_irq_n,
  input wire logic i_vector_fetch,
  input wire logic i_break_state,
  output logic o_cpu_irq,
  output logic o_stop_wake
);

  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic [2:0] arm;
  logic irq_latch;
  logic mask_bit;
  logic break_clear_enable;
  ext_irq_pkg::sense_t sense;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // Word match shared by the register decodes
  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    return a == b;
  endfunction

  wire logic access = i_psel && i_penable;
  wire logic wr = access && i_pwrite && i_pstrb[0];
  wire logic sel_sc = hit(i_paddr, `STATUS_CONTROL_ADDR);
  wire logic sel_bf = hit(i_paddr, `BREAK_CONTROL_ADDR);
  wire logic sel_pin = hit(i_paddr, `PIN_LEVEL_ADDR);
  wire logic mapped = sel_sc || sel_bf || sel_pin;
  wire logic level_mode = (sense == ext_irq_pkg::sense_edge_level);
  // Edges ignored until the pin stages hold real samples after reset,
  // so a pin held low through reset raises no false request
  wire logic armed = arm[2];
  wire logic fall = armed && pin_prev && !pin_sync;
  // Only an edge sets the latch; in level mode the low level is added to pending,
  // so an acknowledge taken while the pin is low is not lost
  wire logic trigger = fall; // RQ1 RQ6
  // Software acknowledge blocked in break unless enabled; vector fetch still clears
  wire logic clr_ok = !i_break_state || break_clear_enable; // RQ16 RQ17 RQ18
  wire logic sw_ack = wr && sel_sc && i_pwdata[`BIT_ACK] && clr_ok; // RQ3
  wire logic ack = sw_ack || i_vector_fetch; // RQ2
  // Level mode keeps request while pin is low
  wire logic pending = irq_latch || (level_mode && !pin_sync); // RQ10 RQ11 RQ21
  wire logic next_latch = trigger ? 1'b1 : (ack ? 1'b0 : irq_latch); // RQ6

  // Two-flop synchroniser, first stage read only by the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta <= `PIN_IDLE;
      pin_sync <= `PIN_IDLE;
      pin_prev <= `PIN_IDLE;
    end else begin
      pin_meta <= i_irq_n;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Arming delay covers both sync stages and the edge flop
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      arm <= 3'h0;
    end else begin
      arm <= {arm[1:0], 1'b1};
    end
  end

  // Set wins over acknowledge in the same cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_latch <= 1'b0; // RQ4 RQ12
    end else begin
      irq_latch <= next_latch; // RQ13
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_bit <= `MASK_RESET;
      sense <= ext_irq_pkg::sense_edge; // RQ5 RQ12
      break_clear_enable <= `BREAK_CLEAR_ENABLE_RESET;
    end else begin
      if (wr && sel_sc) begin
        mask_bit <= i_pwdata[`BIT_MASK];
        sense <= ext_irq_pkg::sense_t'(i_pwdata[`BIT_SENSE]); // RQ21
      end
      if (wr && sel_bf) begin
        break_clear_enable <= i_pwdata[`BIT_BREAK_CLEAR_ENABLE];
      end
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (sel_sc) begin
      next_rdata[`BIT_PENDING] = pending; // RQ7 RQ19
      next_rdata[`BIT_MASK] = mask_bit;
      next_rdata[`BIT_SENSE] = level_mode;
      next_rdata[`BIT_ACK] = 1'b0; // RQ20
    end else if (sel_bf) begin
      next_rdata[`BIT_BREAK_CLEAR_ENABLE] = break_clear_enable;
    end else if (sel_pin) begin
      next_rdata[0] = pin_sync;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Read data registered in setup, so access phase is one cycle
  assign o_prdata = rdata;
  assign o_pready = i_psel && i_penable;
  assign o_pslverr = access && !mapped;
  // Outside CPU applies its own global mask
  assign o_cpu_irq = pending && !mask_bit; // RQ8 RQ9 RQ14 RQ22
  // Wake is combinational from the raw pin so it works with clocks stopped
  assign o_stop_wake = !mask_bit && (!i_irq_n || irq_latch); // RQ15

  sequence fall_seen;
    fall;
  endsequence

  property edge_sets;
    @(posedge i_clk) disable iff (i_rst)
      fall_seen |=> irq_latch;
  endproperty

  edge_sets_a: assert property (edge_sets) // RQ1
    else $error("falling edge did not set latch");

  ack_clears_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ack && !trigger |=> !irq_latch) // RQ2
    else $error("acknowledge did not clear latch");

  sw_ack_a: assert property (@(posedge i_clk) disable iff (i_rst)
    sw_ack && !trigger && !level_mode && !i_pwdata[`BIT_SENSE]
      |=> !o_cpu_irq) // RQ3
    else $error("software ack left request");

  pending_mask_a: assert property (@(posedge i_clk) disable iff (i_rst)
    sel_sc && irq_latch && mask_bit |=> rdata[`BIT_PENDING]) // RQ7
    else $error("pending hidden by mask");

  mask_blocks_a: assert property (@(posedge i_clk) disable iff (i_rst)
    mask_bit |-> !o_cpu_irq) // RQ8
    else $error("masked request reached cpu");

  level_holds_a: assert property (@(posedge i_clk) disable iff (i_rst)
    level_mode && !pin_sync && !mask_bit |-> o_cpu_irq) // RQ10
    else $error("level request dropped while pin low");

  break_freeze_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_break_state && !break_clear_enable && irq_latch && !i_vector_fetch
      |=> irq_latch) // RQ17
    else $error("status changed in protected break");

  ack_reads_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(sel_sc) |-> !rdata[`BIT_ACK]) // RQ20
    else $error("acknowledge bit read nonzero");

  edge_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !level_mode && ack && !trigger ##1 (!fall && !level_mode)
      |-> !pending) // RQ13
    else $error("edge mode ack did not clear");

  // Steps shared by the acknowledge and level checks
  sequence ack_seen;
    ack && !trigger;
  endsequence

  sequence level_low;
    level_mode && !pin_sync;
  endsequence

  // Vector fetch alone must clear the latch
  property fetch_clears;
    @(posedge i_clk) disable iff (i_rst)
      i_vector_fetch && !trigger |=> !irq_latch;
  endproperty
  fetch_clears_a: assert property (fetch_clears) // RQ2
    else $error("vector fetch did not clear latch");

  // Software acknowledge alone must clear the latch
  property sw_clears;
    @(posedge i_clk) disable iff (i_rst)
      sw_ack && !trigger |=> !irq_latch;
  endproperty
  sw_clears_a: assert property (sw_clears) // RQ3
    else $error("software ack did not clear latch");

  // In edge mode nothing but the latch makes a request
  property edge_only;
    @(posedge i_clk) disable iff (i_rst)
      !level_mode && !irq_latch |-> !pending;
  endproperty
  edge_only_a: assert property (edge_only) // RQ5
    else $error("edge mode pending without latch");

  // An edge after an acknowledge latches a new request
  property retrigger;
    @(posedge i_clk) disable iff (i_rst)
      ack_seen ##1 fall |=> irq_latch;
  endproperty
  retrigger_a: assert property (retrigger) // RQ6
    else $error("edge after ack not latched");

  // Read image of the flag follows pending of the setup cycle
  property pend_image;
    @(posedge i_clk) disable iff (i_rst)
      sel_sc |=> rdata[`BIT_PENDING] == $past(pending);
  endproperty
  pend_image_a: assert property (pend_image) // RQ19
    else $error("pending flag read wrong");

  property no_pend_read;
    @(posedge i_clk) disable iff (i_rst)
      sel_sc && !pending |=> !rdata[`BIT_PENDING];
  endproperty
  no_pend_read_a: assert property (no_pend_read) // RQ19
    else $error("pending flag read one when idle");

  property mask_image;
    @(posedge i_clk) disable iff (i_rst)
      sel_sc |=> rdata[`BIT_MASK] == $past(mask_bit);
  endproperty
  mask_image_a: assert property (mask_image) // RQ8
    else $error("mask bit read wrong");

  // Unmasked pending reaches the CPU, also in wait mode
  property unmasked_irq;
    @(posedge i_clk) disable iff (i_rst)
      pending && !mask_bit |-> o_cpu_irq;
  endproperty
  unmasked_irq_a: assert property (unmasked_irq) // RQ14 RQ22
    else $error("unmasked request not raised");

  property idle_irq;
    @(posedge i_clk) disable iff (i_rst)
      !pending |-> !o_cpu_irq;
  endproperty
  idle_irq_a: assert property (idle_irq) // RQ22
    else $error("request raised with nothing pending");

  // In level mode an acknowledge while the pin stays low keeps the request
  property level_keep;
    @(posedge i_clk) disable iff (i_rst)
      level_low ##0 ack ##1 level_low |-> pending;
  endproperty
  level_keep_a: assert property (level_keep) // RQ10
    else $error("level request dropped by ack");

  // Pin high and latch clear: request gone
  property level_clear;
    @(posedge i_clk) disable iff (i_rst)
      level_mode && pin_sync && !irq_latch |-> !pending;
  endproperty
  level_clear_a: assert property (level_clear) // RQ11
    else $error("level request stuck after both steps");

  // Pin back high first: latch waits for the acknowledge
  property level_wait_ack;
    @(posedge i_clk) disable iff (i_rst)
      level_mode && pin_sync && irq_latch && !ack |=> irq_latch;
  endproperty
  level_wait_ack_a: assert property (level_wait_ack) // RQ11
    else $error("level latch cleared without ack");

  // Stop wake needs no clock: combinational from pin and latch
  property wake_latch;
    @(posedge i_clk) disable iff (i_rst)
      !mask_bit && irq_latch |-> o_stop_wake;
  endproperty
  wake_latch_a: assert property (wake_latch) // RQ15
    else $error("no wake with latched request");

  property wake_pin;
    @(posedge i_clk) disable iff (i_rst)
      !mask_bit && !i_irq_n |-> o_stop_wake;
  endproperty
  wake_pin_a: assert property (wake_pin) // RQ15
    else $error("no wake with pin low");

  property wake_masked;
    @(posedge i_clk) disable iff (i_rst)
      mask_bit |-> !o_stop_wake;
  endproperty
  wake_masked_a: assert property (wake_masked) // RQ15
    else $error("wake raised while masked");

  // Enabled break clears take effect
  property break_clear_ok;
    @(posedge i_clk) disable iff (i_rst)
      i_break_state && break_clear_enable && sw_ack && !trigger |=> !irq_latch;
  endproperty
  break_clear_ok_a: assert property (break_clear_ok) // RQ16
    else $error("enabled break clear ignored");

  property break_no_ack;
    @(posedge i_clk) disable iff (i_rst)
      i_break_state && !break_clear_enable |-> !sw_ack;
  endproperty
  break_no_ack_a: assert property (break_no_ack) // RQ17 RQ18
    else $error("ack accepted in protected break");

  property sense_image;
    @(posedge i_clk) disable iff (i_rst)
      sel_sc |=> rdata[`BIT_SENSE] == $past(level_mode);
  endproperty
  sense_image_a: assert property (sense_image) // RQ21
    else $error("sensitivity bit read wrong");

  // Bus answers in the first access cycle
  property zero_wait;
    @(posedge i_clk) disable iff (i_rst)
      i_psel && i_penable |-> o_pready;
  endproperty
  zero_wait_a: assert property (zero_wait)
    else $error("access phase without ready");

  property unmapped_err;
    @(posedge i_clk) disable iff (i_rst)
      i_psel && i_penable && !mapped |-> o_pslverr;
  endproperty
  unmapped_err_a: assert property (unmapped_err)
    else $error("unmapped access without error");

endmodule

// *** pkg/ext_irq_defines.svh ***
// Register offsets, bit positions and reset values of the external interrupt
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH
`define STATUS_CONTROL_ADDR 12'h000
`define BREAK_CONTROL_ADDR 12'h004
`define PIN_LEVEL_ADDR 12'h008
`define BIT_SENSE 0
`define BIT_MASK 1
`define BIT_ACK 2
`define BIT_PENDING 3
`define BIT_BREAK_CLEAR_ENABLE 0
`define SENSE_RESET 1'b0
`define MASK_RESET 1'b0
`define BREAK_CLEAR_ENABLE_RESET 1'b0
`define PIN_IDLE 1'b1
`endif

// *** pkg/ext_irq_pkg.sv ***
// Types of the external interrupt pin latch
package ext_irq_pkg;
  typedef enum logic {
    sense_edge,
    sense_edge_level
  } sense_t;
endpackage

// *** tb/irq_source_model.sv ***
// Pin driver and vector fetch source on the far side of the latch
`timescale 1ns/10ps
module irq_source_model (
  input wire logic i_clk,
  input wire logic i_low,
  input wire logic i_fetch,
  input wire logic i_cpu_irq,
  input wire logic i_gmask,
  output logic o_taken,
  output logic o_irq_n = 1'b1,
  output logic o_vector_fetch = 1'b0
);
  // CPU global mask blocks every request
  assign o_taken = i_cpu_irq && !i_gmask;
  // Pull-up keeps the pin high unless a source drives it low
  always_ff @(posedge i_clk) begin
    o_irq_n <= !i_low;
    o_vector_fetch <= i_fetch;
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the external interrupt pin latch
`timescale 1ns/10ps
module testbench;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err, irq_n, fetch, brk = 0, cpu_irq, wake;
  logic low = 0, fcmd = 0, gmask = 0, taken;
  int bad_count = 0, n_tests = 0;
  initial forever #4 clk = ~clk;
  external_irq_pin_latch external_irq_pin_latch_inst (.i_clk(clk),
    .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_irq_n(irq_n),
    .i_vector_fetch(fetch), .i_break_state(brk), .o_cpu_irq(cpu_irq),
    .o_stop_wake(wake));
  irq_source_model irq_source_model_inst (.i_clk(clk), .i_low(low),
    .i_fetch(fcmd), .i_cpu_irq(cpu_irq), .i_gmask(gmask),
    .o_taken(taken), .o_irq_n(irq_n), .o_vector_fetch(fetch));
  task automatic wrap_up;
    $display("tests %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
      bad_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin bad_count++; wrap_up; end
      @(posedge clk);
    end
    q = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic st(input logic [31:0] e);
    apb(0, 12'h000, 0);
    chk(q, e);
  endtask
  task automatic pin(input logic l);
    @(posedge clk);
    low <= l;
    repeat (6) @(posedge clk);
  endtask
  task automatic t_edge;
    st(32'h0);
    pin(1);
    st(32'h8);
    chk(cpu_irq, 1);
    apb(1, 12'h000, 32'h4);
    st(32'h0);
    pin(0); pin(1);
    st(32'h8);
    @(posedge clk) fcmd <= 1;
    @(posedge clk) fcmd <= 0;
    pin(0);
    st(32'h0);
    $display("edge test done");
  endtask
  task automatic t_mask;
    apb(1, 12'h000, 32'h2);
    pin(1);
    st(32'hA);
    chk({cpu_irq, wake}, 0);
    apb(1, 12'h000, 32'h4);
    apb(1, 12'h000, 32'h0);
    pin(0); pin(1);
    chk({cpu_irq, wake}, 3);
    chk(taken, 1);
    @(posedge clk) gmask <= 1;
    @(posedge clk) chk(taken, 0);
    gmask <= 0;
    apb(1, 12'h000, 32'h5);
    st(32'h9);
    pin(0);
    st(32'h1);
    pin(1);
    @(posedge clk) rst <= 1;
    @(posedge clk) chk(cpu_irq, 0);
    rst <= 0;
    repeat (6) @(posedge clk);
    st(32'h0);
    pin(0);
    $display("mask and level test done");
  endtask
  task automatic t_break;
    apb(1, 12'h000, 32'h4);
    pin(1); pin(0);
    @(posedge clk) brk <= 1;
    apb(1, 12'h000, 32'h4);
    st(32'h8);
    apb(1, 12'h004, 32'h1);
    apb(1, 12'h000, 32'h4);
    @(posedge clk) brk <= 0;
    st(32'h0);
    apb(0, 12'h00C, 0);
    chk({q[0], err}, 1);
    apb(0, 12'h008, 0);
    chk(q, 1);
    $display("break test done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    t_edge;
    t_mask;
    t_break;
    wrap_up;
  end
endmodule
